//--- core/io_link_pkg.sv
// shared constants, types and parity helpers for the i/o channel link
package io_link_pkg;
    localparam int BYTE_W         = 12;
    localparam int WORD_W         = 24;
    localparam int EQUIP_N        = 8;
    localparam int EQUIP_W        = 3;
    localparam int STATUS_W       = 12;
    localparam int FIFO_DEPTH     = 4;
    localparam int CLK_MHZ        = 100;
    localparam int REJECT_TIME_US = 100;
    localparam int REJECT_CYCLES  = REJECT_TIME_US * CLK_MHZ;
    // one sense for every party on the link
    localparam logic ODD_PARITY   = 1'b1;

    typedef enum logic [2:0] {
        op_attach   = 3'b000,
        op_function = 3'b001,
        op_write    = 3'b011,
        op_read     = 3'b010,
        op_clear    = 3'b110
    } op_t;

    typedef enum logic [1:0] {
        mode_narrow    = 2'b00,
        mode_wide_asm  = 2'b01,
        mode_wide_full = 2'b11
    } mode_t;

    function automatic logic byte_parity(input logic [BYTE_W-1:0] b);
        return (^b) ^ ODD_PARITY;
    endfunction

    function automatic logic [1:0] word_parity(input logic [WORD_W-1:0] w);
        return {byte_parity(w[WORD_W-1:BYTE_W]), byte_parity(w[BYTE_W-1:0])};
    endfunction
endpackage

//--- core/io_link_if.sv
// link between one channel end and the controllers on its cable
`timescale 1ns/1ps
`default_nettype none
interface io_link_if
    import io_link_pkg::*;
    ();
    // channel to controller
    logic                ch_valid;
    op_t                 ch_op;
    logic [EQUIP_W-1:0]  ch_equip;
    mode_t               ch_mode;
    logic [WORD_W-1:0]   ch_data;
    logic [1:0]          ch_par;
    logic                ch_clear;
    logic                ch_ready;
    // controller to channel
    logic                ct_reply;
    logic                ct_reject;
    logic                ct_ext_perr;
    logic                ct_valid;
    logic [WORD_W-1:0]   ct_data;
    logic [1:0]          ct_par;
    logic [STATUS_W-1:0] ct_status;
    logic [EQUIP_N-1:0]  ct_irq;

    modport channel (
        output ch_valid, ch_op, ch_equip, ch_mode, ch_data, ch_par, ch_clear, ch_ready,
        input  ct_reply, ct_reject, ct_ext_perr, ct_valid, ct_data, ct_par, ct_status, ct_irq
    );
    modport controller (
        input  ch_valid, ch_op, ch_equip, ch_mode, ch_data, ch_par, ch_clear, ch_ready,
        output ct_reply, ct_reject, ct_ext_perr, ct_valid, ct_data, ct_par, ct_status, ct_irq
    );
endinterface
`default_nettype wire

//--- core/io_channel_end.sv
// channel end: command sequencing, byte assembly, parity check and read fifo
`timescale 1ns/1ps
`default_nettype none
module io_word_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 4
) (
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             reset,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [PTR_W:0]   count;
    logic             push;
    logic             pop;

    assign in_ready  = (count != (PTR_W+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data  = mem[rd_ptr];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == PTR_W'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == PTR_W'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule

module io_channel_end
    import io_link_pkg::*;
#(
    parameter bit WIDE            = 1'b1,
    parameter int CHANNEL_NUM     = 0,
    parameter int REJECT_CYCLES_P = REJECT_CYCLES,
    parameter int FIFO_DEPTH_P    = FIFO_DEPTH
) (
    // clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 reset,
    // link
    io_link_if.channel                link,
    // commands from the computation section
    input  wire logic                 cmd_valid,
    output logic                      cmd_ready,
    input  wire op_t                  cmd_op,
    input  wire logic [EQUIP_W-1:0]   cmd_equip,
    input  wire logic                 cmd_word,
    input  wire logic                 cmd_full24,
    input  wire logic [WORD_W-1:0]    cmd_data,
    // command results
    output logic                      cmd_done,
    output logic                      cmd_reply,
    output logic                      cmd_reject,
    output logic                      int_reject,
    // read data toward storage
    output logic                      rd_valid,
    input  wire logic                 rd_ready,
    output logic [WORD_W-1:0]         rd_data,
    // sense and status
    output logic                      sense_parity,
    output logic                      connected,
    output logic [EQUIP_W-1:0]        conn_equip,
    output logic [STATUS_W-1:0]       status,
    output logic [EQUIP_N-1:0]        irq
);
    typedef enum logic [1:0] {
        st_idle   = 2'b00,
        st_send   = 2'b01,
        st_answer = 2'b11
    } chan_state_t;

    localparam bit WIDE_OK = WIDE && (CHANNEL_NUM % 2 == 0) && (CHANNEL_NUM < EQUIP_N);
    localparam int TMR_W   = $clog2(REJECT_CYCLES_P + 1);

    chan_state_t       state;
    logic              resend;
    logic [WORD_W-1:0] cur_word;
    logic [TMR_W-1:0]  timer;
    logic              read_active;
    logic              hi_phase;
    logic [BYTE_W-1:0] asm_lo;
    logic              answered;
    logic              timeout;
    logic              accept;
    logic              take_in;
    logic              read_err;
    logic              fifo_in_ready;
    logic              push_valid;
    logic [WORD_W-1:0] push_data;
    mode_t             next_mode;

    assign cmd_ready = (state == st_idle);
    assign accept    = cmd_valid & cmd_ready;
    assign timeout   = (state == st_send) && (timer == TMR_W'(REJECT_CYCLES_P - 1));
    assign answered  = link.ct_reply | link.ct_reject | link.ct_ext_perr | timeout;

    // wide modes only on an even wide channel and word addressing
    always_comb begin
        if (!WIDE_OK || !cmd_word) begin
            next_mode = mode_narrow;
        end else if (cmd_full24) begin
            next_mode = mode_wide_full;
        end else begin
            next_mode = mode_wide_asm;
        end
    end

    // outgoing sequencing
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state         <= st_idle;
            resend        <= 1'b0;
            cur_word      <= '0;
            timer         <= '0;
            cmd_done      <= 1'b0;
            link.ch_valid <= 1'b0;
            link.ch_op    <= op_attach;
            link.ch_equip <= '0;
            link.ch_mode  <= mode_narrow;
            link.ch_data  <= '0;
            link.ch_par   <= '0;
            link.ch_clear <= 1'b0;
        end else begin
            cmd_done      <= 1'b0;
            link.ch_clear <= 1'b0;
            timer         <= (state == st_send) ? timer + 1'b1 : '0;
            case (state)
                st_idle: begin
                    if (accept && cmd_op == op_clear) begin
                        link.ch_clear <= 1'b1;
                        cmd_done      <= 1'b1;
                    end else if (accept) begin
                        cur_word      <= cmd_data;
                        link.ch_valid <= 1'b1;
                        link.ch_op    <= cmd_op;
                        link.ch_equip <= cmd_equip;
                        link.ch_mode  <= next_mode;
                        if (cmd_op == op_write && next_mode != mode_wide_full) begin
                            link.ch_data <= {{BYTE_W{1'b0}}, cmd_data[BYTE_W-1:0]};
                            link.ch_par  <= word_parity({{BYTE_W{1'b0}}, cmd_data[BYTE_W-1:0]});
                        end else begin
                            link.ch_data <= cmd_data;
                            link.ch_par  <= word_parity(cmd_data);
                        end
                        state <= st_send;
                    end
                end
                st_send: begin
                    if (answered) begin
                        link.ch_valid <= 1'b0;
                        resend <= link.ct_reply && link.ch_op == op_write
                                  && link.ch_mode == mode_wide_asm && !resend;
                        state  <= st_answer;
                    end
                end
                st_answer: begin
                    if (resend) begin
                        link.ch_valid <= 1'b1;
                        link.ch_data  <= {{BYTE_W{1'b0}}, cur_word[WORD_W-1:BYTE_W]};
                        link.ch_par   <= word_parity({{BYTE_W{1'b0}}, cur_word[WORD_W-1:BYTE_W]});
                        state         <= st_send;
                    end else begin
                        cmd_done <= 1'b1;
                        state    <= st_idle;
                    end
                end
                default: begin
                    state <= st_idle;
                end
            endcase
        end
    end

    // answer flags stand until the next command
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            cmd_reply  <= 1'b0;
            cmd_reject <= 1'b0;
            int_reject <= 1'b0;
        end else if (accept) begin
            cmd_reply  <= 1'b0;
            cmd_reject <= 1'b0;
            int_reject <= 1'b0;
        end else if (state == st_send && answered) begin
            cmd_reply  <= link.ct_reply;
            cmd_reject <= link.ct_reject;
            int_reject <= timeout && !link.ct_reply && !link.ct_reject && !link.ct_ext_perr;
        end
    end

    // connection bookkeeping; a new attach drops the old connection first
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            connected  <= 1'b0;
            conn_equip <= '0;
        end else if (accept && (cmd_op == op_attach || cmd_op == op_clear)) begin
            connected  <= 1'b0;
            conn_equip <= cmd_equip;
        end else if (state == st_send && link.ch_op == op_attach && link.ct_reply) begin
            connected <= 1'b1;
        end
    end

    // status gated by connection; interrupts pass whether connected or not
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            status <= '0;
            irq    <= '0;
        end else begin
            status <= connected ? link.ct_status : '0;
            irq    <= link.ct_irq;
        end
    end

    // read stream: assembly and parity compare on every accepted byte
    assign link.ch_ready = read_active & fifo_in_ready;
    assign take_in       = link.ct_valid & link.ch_ready;
    assign read_err      = take_in && (link.ct_par != word_parity(link.ct_data));
    assign push_valid    = take_in && (link.ch_mode != mode_wide_asm || hi_phase);
    assign push_data     = (link.ch_mode == mode_wide_asm) ? {link.ct_data[BYTE_W-1:0], asm_lo}
                                                           : link.ct_data;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            read_active <= 1'b0;
            hi_phase    <= 1'b0;
            asm_lo      <= '0;
        end else if (accept) begin
            read_active <= 1'b0;
            hi_phase    <= 1'b0;
        end else begin
            if (state == st_send && link.ch_op == op_read && link.ct_reply) begin
                read_active <= 1'b1;
            end
            if (take_in && link.ch_mode == mode_wide_asm) begin
                hi_phase <= !hi_phase;
                if (!hi_phase) begin
                    asm_lo <= link.ct_data[BYTE_W-1:0];
                end
            end
        end
    end

    // sense line zero; a set in the clearing cycle wins
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            sense_parity <= 1'b0;
        end else if (read_err || (state == st_send && link.ct_ext_perr)) begin
            sense_parity <= 1'b1;
        end else if (accept) begin
            sense_parity <= 1'b0;
        end
    end

    io_word_fifo #(
        .WIDTH (WORD_W),
        .DEPTH (FIFO_DEPTH_P)
    ) read_fifo (
        .core_clk  (core_clk),
        .reset     (reset),
        .in_valid  (push_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (push_data),
        .out_valid (rd_valid),
        .out_ready (rd_ready),
        .out_data  (rd_data)
    );
endmodule
`default_nettype wire

//--- core/io_ctrl_end.sv
// peripheral controller end: attach, parity check, data hand-off and read stream
`timescale 1ns/1ps
`default_nettype none
module io_ctrl_end
    import io_link_pkg::*;
#(
    parameter logic [EQUIP_W-1:0] EQUIP = 3'h0
) (
    // clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 reset,
    // link
    io_link_if.controller             link,
    // received function and write data
    output logic                      wr_valid,
    output logic                      wr_is_function,
    output logic [WORD_W-1:0]         wr_data,
    // device side
    input  wire logic [STATUS_W-1:0]  dev_status,
    input  wire logic                 irq_req,
    input  wire logic                 dev_clear,
    // read data from the device
    input  wire logic                 rd_valid,
    output logic                      rd_ready,
    input  wire logic [WORD_W-1:0]    rd_data,
    // indicators
    output logic                      connected,
    output logic                      read_mode,
    output logic                      perr_light,
    output logic                      inactive
);
    logic seen;
    logic take;
    logic par_ok;
    logic chan_cleared;
    logic dev_cleared;
    logic load;

    assign take     = link.ch_valid && !seen && !inactive;
    assign par_ok   = (link.ch_par == word_parity(link.ch_data));
    assign rd_ready = read_mode && (!link.ct_valid || link.ch_ready);
    assign load     = rd_valid && rd_ready;

    // answer once per request
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            seen <= 1'b0;
        end else begin
            seen <= link.ch_valid;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            link.ct_reply    <= 1'b0;
            link.ct_reject   <= 1'b0;
            link.ct_ext_perr <= 1'b0;
            connected        <= 1'b0;
            read_mode        <= 1'b0;
            perr_light       <= 1'b0;
            wr_valid         <= 1'b0;
            wr_is_function   <= 1'b0;
            wr_data          <= '0;
        end else begin
            link.ct_reply    <= 1'b0;
            link.ct_reject   <= 1'b0;
            link.ct_ext_perr <= 1'b0;
            wr_valid         <= 1'b0;
            if (link.ch_clear) begin
                connected <= 1'b0;
                read_mode <= 1'b0;
            end else if (take) begin
                read_mode <= 1'b0;
                if (link.ch_op == op_attach) begin
                    connected <= (link.ch_equip == EQUIP) && par_ok;
                    if (link.ch_equip == EQUIP) begin
                        link.ct_reply <= par_ok;
                        perr_light    <= perr_light | !par_ok;
                    end
                end else if (!connected) begin
                    link.ct_reject <= (link.ch_equip == EQUIP);
                end else if (link.ch_op == op_read) begin
                    link.ct_reply <= 1'b1;
                    read_mode     <= 1'b1;
                end else if (!par_ok) begin
                    link.ct_ext_perr <= 1'b1;
                    perr_light       <= 1'b1;
                end else begin
                    link.ct_reply  <= 1'b1;
                    wr_valid       <= 1'b1;
                    wr_is_function <= (link.ch_op == op_function);
                    wr_data        <= link.ch_data;
                end
            end
        end
    end

    // after a function or write parity error wait for both clears
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            inactive     <= 1'b0;
            chan_cleared <= 1'b0;
            dev_cleared  <= 1'b0;
        end else if (take && connected && !par_ok
                     && (link.ch_op == op_function || link.ch_op == op_write)) begin
            inactive     <= 1'b1;
            chan_cleared <= 1'b0;
            dev_cleared  <= 1'b0;
        end else if (inactive) begin
            chan_cleared <= chan_cleared | link.ch_clear;
            dev_cleared  <= dev_cleared | dev_clear;
            if ((chan_cleared | link.ch_clear) && (dev_cleared | dev_clear)) begin
                inactive <= 1'b0;
            end
        end
    end

    // read stream with one holding stage
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            link.ct_valid <= 1'b0;
            link.ct_data  <= '0;
            link.ct_par   <= '0;
        end else if (!read_mode) begin
            link.ct_valid <= 1'b0;
        end else if (load) begin
            link.ct_valid <= 1'b1;
            link.ct_data  <= rd_data;
            link.ct_par   <= word_parity(rd_data);
        end else if (link.ch_ready) begin
            link.ct_valid <= 1'b0;
        end
    end

    // status only while connected, interrupt at any time
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            link.ct_status <= '0;
            link.ct_irq    <= '0;
        end else begin
            link.ct_status <= connected ? dev_status : '0;
            link.ct_irq    <= EQUIP_N'(irq_req) << EQUIP;
        end
    end
endmodule
`default_nettype wire

//--- test/io_link_properties.sv
// interface assertions for the channel link
`timescale 1ns/1ps
`default_nettype none
module io_link_properties
    import io_link_pkg::*;
(
    // clock and reset
    input wire logic               core_clk,
    input wire logic               reset,
    // channel side
    input wire logic               ch_valid,
    input wire logic [EQUIP_W-1:0] ch_equip,
    input wire logic [WORD_W-1:0]  ch_data,
    input wire logic [1:0]         ch_par,
    input wire logic               ch_clear,
    // controller side
    input wire logic               ct_reply,
    input wire logic               ct_reject,
    input wire logic               ct_valid,
    input wire logic [WORD_W-1:0]  ct_data,
    input wire logic [1:0]         ct_par,
    input wire logic [EQUIP_N-1:0] ct_irq
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    sequence s_req; $rose(ch_valid) && ch_equip == 3'h0; endsequence
    sequence s_ans; ##1 (ct_reply || ct_reject); endsequence
    property p_par; ch_valid |-> ch_par == {~^ch_data[23:12], ~^ch_data[11:0]}; endproperty
    a_par: assert property (p_par) else $error("bad outgoing parity");
    property p_rdpar; ct_valid |-> ct_par == {~^ct_data[23:12], ~^ct_data[11:0]}; endproperty
    a_rdpar: assert property (p_rdpar) else $error("bad read parity");
    property p_answer; s_req |-> s_ans; endproperty
    a_answer: assert property (p_answer) else $error("controller did not answer");
    property p_hold; $rose(ch_valid) |=> ch_valid && $stable(ch_data); endproperty
    a_hold: assert property (p_hold) else $error("request not held");
    property p_once; ct_reply |=> !ct_reply; endproperty
    a_once: assert property (p_once) else $error("reply longer than a pulse");
    property p_cause; ct_reply || ct_reject |-> $past(ch_valid); endproperty
    a_cause: assert property (p_cause) else $error("answer without request");
    property p_clr; ch_clear |-> !ch_valid ##1 !ch_clear; endproperty
    a_clr: assert property (p_clr) else $error("clear not a lone pulse");
    property p_irq; ct_irq[7:1] == 7'h00; endproperty
    a_irq: assert property (p_irq) else $error("interrupt on foreign line");
endmodule
`default_nettype wire

//--- test/io_channel_parity_link_tb.sv
// self-checking bench for both ends of the channel link
`timescale 1ns/1ps
`default_nettype none
module io_channel_parity_link_tb import io_link_pkg::*;;
    typedef struct packed {
        op_t o; logic w; logic f; logic [2:0] e; logic [23:0] d; logic [2:0] r; logic [23:0] wd;
    } row_t;
    logic core_clk = 0, reset = 1, cmd_valid = 0, cmd_word = 0, cmd_full24 = 0;
    logic rd_ready = 0, irq_req = 0, dev_clear = 0, dv_valid = 0;
    op_t         cmd_op = op_attach;
    logic [2:0]  cmd_equip = 0, ans;
    logic [23:0] cmd_data = 0, rd_data, wr_data, dv_data = 0;
    logic        cmd_ready, cmd_done, cmd_reply, cmd_reject, int_reject, rd_valid, sense_parity;
    logic        c_ready, perr_b, inact_b, conn_b;
    logic [11:0] status;
    logic [7:0]  irq;
    int          bad_count = 0, n_checks = 0, sent = 0, j;
    row_t rows [8] = '{
        '{op_clear, 1'b0, 1'b0, 3'h0, 24'h0, 3'b000, 24'h0},
        '{op_attach, 1'b0, 1'b0, 3'h5, 24'h0, 3'b100, 24'h0},
        '{op_write, 1'b1, 1'b1, 3'h0, 24'h0, 3'b010, 24'h0},
        '{op_attach, 1'b0, 1'b0, 3'h0, 24'h0, 3'b001, 24'h0},
        '{op_function, 1'b1, 1'b1, 3'h0, 24'h12_3456, 3'b001, 24'h12_3456},
        '{op_write, 1'b0, 1'b0, 3'h0, 24'hFE_DCBA, 3'b001, 24'h00_0CBA},
        '{op_write, 1'b1, 1'b0, 3'h0, 24'h65_4321, 3'b001, 24'h00_0654},
        '{op_read, 1'b1, 1'b0, 3'h0, 24'h0, 3'b001, 24'h00_0654}};
    io_link_if link_a ();
    io_link_if link_b ();
    io_channel_end #(.REJECT_CYCLES_P(20)) u_io_channel_end (.core_clk, .reset, .link(link_a.channel),
        .cmd_valid, .cmd_ready, .cmd_op, .cmd_equip, .cmd_word, .cmd_full24, .cmd_data, .cmd_done,
        .cmd_reply, .cmd_reject, .int_reject, .rd_valid, .rd_ready, .rd_data, .sense_parity,
        .connected(), .conn_equip(), .status, .irq);
    io_ctrl_end u_io_ctrl_end (.core_clk, .reset, .link(link_a.controller), .wr_valid(), .wr_is_function(),
        .wr_data, .dev_status(12'h5A5), .irq_req, .dev_clear, .rd_valid(dv_valid), .rd_ready(c_ready),
        .rd_data(dv_data), .connected(), .read_mode(), .perr_light(), .inactive());
    // fault side: the bench plays the channel and breaks parity on purpose
    io_ctrl_end u_io_ctrl_end_b (.core_clk, .reset, .link(link_b.controller), .wr_valid(), .wr_is_function(),
        .wr_data(), .dev_status(12'h5A5), .irq_req, .dev_clear, .rd_valid(dv_valid), .rd_ready(),
        .rd_data(dv_data), .connected(conn_b), .read_mode(), .perr_light(perr_b), .inactive(inact_b));
    io_link_properties u_props (.core_clk, .reset, .ch_valid(link_a.ch_valid), .ch_equip(link_a.ch_equip),
        .ch_data(link_a.ch_data), .ch_par(link_a.ch_par), .ch_clear(link_a.ch_clear),
        .ct_reply(link_a.ct_reply), .ct_reject(link_a.ct_reject), .ct_valid(link_a.ct_valid),
        .ct_data(link_a.ct_data), .ct_par(link_a.ct_par), .ct_irq(link_a.ct_irq));
    always #5 core_clk = ~core_clk;
    // device stream: twelve bytes counting up from zero
    always @(posedge core_clk) if (dv_valid && c_ready) begin
        dv_data <= dv_data + 24'h1;
        sent <= sent + 1;
        if (sent == 11) dv_valid <= 1'b0;
    end
    function automatic logic [1:0] bpar(input logic [23:0] d);
        return {~^d[23:12], ~^d[11:0]};
    endfunction
    task automatic chk(input string n, input logic [23:0] e, input logic [23:0] s);
        n_checks++;
        if (s !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic cmd(input row_t r);
        int n = 0;
        {cmd_op, cmd_word, cmd_full24, cmd_equip, cmd_data} <= {r.o, r.w, r.f, r.e, r.d};
        cmd_valid <= 1'b1;
        do @(posedge core_clk); while (cmd_ready !== 1'b1 && ++n < 50);
        cmd_valid <= 1'b0;
        do @(posedge core_clk); while (cmd_done !== 1'b1 && ++n < 90);
        // a command that never finishes is a failure even if its flags look right
        if (cmd_done !== 1'b1) bad_count++;
        #1;
    endtask
    task automatic bsend(input op_t o, input logic [23:0] d, input logic [1:0] p);
        ans = 0;
        {link_b.ch_op, link_b.ch_data, link_b.ch_par, link_b.ch_valid} <= {o, d, p, 1'b1};
        repeat (4) begin
            @(posedge core_clk);
            ans = ans | {link_b.ct_ext_perr, link_b.ct_reject, link_b.ct_reply};
        end
        // released bus shows the inverse, not the stale value
        {link_b.ch_data, link_b.ch_valid} <= {~d, 1'b0};
        repeat (2) @(posedge core_clk);
        #1;
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        {link_b.ch_valid, link_b.ch_clear, link_b.ch_ready, link_b.ch_equip} = '0;
        {link_b.ch_op, link_b.ch_mode, link_b.ch_data, link_b.ch_par} = {op_attach, mode_wide_full, 26'h0};
        repeat (12) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        #1 chk("status", 0, status);
        irq_req <= 1'b1;
        repeat (3) @(posedge core_clk);
        #1 chk("irq", 8'h01, irq);
        for (int i = 0; i < 8; i++) begin
            cmd(rows[i]);
            chk("result", rows[i].r, {int_reject, cmd_reject, cmd_reply});
            chk("wr_data", rows[i].wd, wr_data);
            chk("sense", 0, sense_parity);
            $display("row %0d done", i);
        end
        chk("status", 12'h5A5, status);
        dv_valid <= 1'b1;
        repeat (40) @(posedge core_clk);
        #1 chk("ch_ready", 0, link_a.ch_ready);
        chk("rd_valid", 1, rd_valid);
        rd_ready <= 1'b1;
        j = 0;
        repeat (80) begin
            @(posedge core_clk);
            if (rd_valid === 1'b1 && j < 6) begin
                chk("rd_data", {12'(2 * j + 1), 12'(2 * j)}, rd_data);
                j++;
            end
        end
        chk("words", 6, j);
        chk("sense", 0, sense_parity);
        $display("stream test done");
        bsend(op_attach, 24'h0, ~bpar(24'h0));
        chk("bad_attach", 0, ans);
        chk("perr_light", 1, perr_b);
        chk("connected", 0, conn_b);
        bsend(op_attach, 24'h0, bpar(24'h0));
        chk("attach", 3'b001, ans);
        bsend(op_write, 24'h12_3456, bpar(24'h12_3456) ^ 2'b10);
        chk("ext_perr", 3'b100, ans);
        bsend(op_attach, 24'h0, bpar(24'h0));
        chk("ignored", 0, ans);
        link_b.ch_clear <= 1'b1;
        @(posedge core_clk);
        link_b.ch_clear <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1 chk("inactive", 1, inact_b);
        dev_clear <= 1'b1;
        @(posedge core_clk);
        dev_clear <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1 chk("inactive", 0, inact_b);
        $display("fault link test done");
        report_and_stop;
    end
    initial begin
        #200_000;
        bad_count++;
        report_and_stop;
    end
endmodule
`default_nettype wire
